// *** include/dlac_cfg.svh ***
// Offsets, field positions, reset values and codes of the debug link access control block
`ifndef DLAC_CFG_SVH
`define DLAC_CFG_SVH
`define DLAC_OFS_LINK_CTRL_B 4'h3
`define DLAC_OFS_KEY_STATUS 4'h7
`define DLAC_OFS_RST_REQ 4'h8
`define DLAC_OFS_ACC_CTRL_A 4'h9
`define DLAC_OFS_SYS_CTRL_A 4'ha
`define DLAC_OFS_SYS_STATE 4'hb
`define DLAC_OFS_CRC_STATE 4'hc
`define DLAC_BIT_NACK_SUPPRESS 4
`define DLAC_BIT_COLL_OFF 3
`define DLAC_BIT_LINK_DISABLE 2
`define DLAC_BIT_KEY_UROW 5
`define DLAC_BIT_KEY_PROG 4
`define DLAC_BIT_KEY_ERASE 3
`define DLAC_BIT_USER_ROW_DONE 1
`define DLAC_BIT_CLK_REQ 0
`define DLAC_BIT_RST_ACTIVE 5
`define DLAC_BIT_ASLEEP 4
`define DLAC_BIT_PROG_READY 3
`define DLAC_BIT_UROW_READY 2
`define DLAC_BIT_LOCK 0
`define DLAC_RST_SIGNATURE 8'h59
`define DLAC_RST_LINK_CTRL_B 8'h00
`define DLAC_RST_CLK_SEL 2'h3
`define DLAC_RST_RST_REQ 1'b0
`define DLAC_CRC_OFF 3'h0
`define DLAC_CRC_BUSY 3'h1
`define DLAC_CRC_GOOD 3'h2
`define DLAC_CRC_FAIL 3'h4
`endif

// *** include/dlac_pkg.sv ***
// Types of the debug link access control block
package dlac_pkg;
    typedef enum logic [1:0] {
        DLAC_CLK_RSVD = 2'h0,
        DLAC_CLK_16M = 2'h1,
        DLAC_CLK_8M = 2'h2,
        DLAC_CLK_4M = 2'h3
    } dlac_clk_sel_t;

    // Register access from the link instruction layer
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } dlac_acc_t;

    // Live levels from the system domain
    typedef struct packed {
        logic in_reset;
        logic asleep;
        logic prog_ready;
        logic urow_ready;
        logic locked;
        logic [2:0] crc_state;
    } dlac_sys_t;

    // Key decode and completion events from the key logic
    typedef struct packed {
        logic urow_key_ok;
        logic prog_key_ok;
        logic erase_key_ok;
        logic prog_done;
        logic erase_done;
    } dlac_key_t;

    typedef struct packed {
        logic negative_ack_suppress;
        logic collision_detect_off;
        logic link_on;
        logic key_urow;
        logic key_prog;
        logic key_erase;
        logic rst_hold;
        dlac_clk_sel_t link_clock_select;
        logic system_clock_request;
        logic user_row_done;
        logic rst_seen;
        logic [7:0] rdata;
    } dlac_state_t;
endpackage

// *** hw/dlac_ctrl.sv ***
// Access control and status registers of the single-wire debug link
`timescale 1ns/1ps
`include "dlac_cfg.svh"

module dlac_ctrl
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link enable request (fuse or high voltage entry)
    input wire logic link_enable,
    // Register access from link instruction layer only
    input wire dlac_pkg::dlac_acc_t acc,
    output logic [7:0] rdata,
    // Link status
    input wire logic load_store_busy,
    input wire logic line_collision,
    // Key logic and system domain
    input wire dlac_pkg::dlac_key_t keys,
    input wire dlac_pkg::dlac_sys_t sys,
    // Outputs to the physical layer
    output logic link_active,
    output logic nack_send,
    output logic collision_flag,
    output dlac_pkg::dlac_clk_sel_t link_clock_select,
    // Outputs to the system domain
    output logic system_reset_hold,
    output logic system_clock_request,
    output logic user_row_done_pulse
);
    import dlac_pkg::*;

    dlac_state_t s_q;
    dlac_state_t s_d;
    // One-cycle start strobe for user row programming, kept outside the register image
    logic urow_done_d;
    logic urow_done_q;
    // Enable level of the previous cycle; a rise re-arms clock request and 4 MHz select
    logic link_on_prev_q;

    // Write strobe decode, shared by every writable register
    function automatic logic hit(input dlac_acc_t a, input logic [3:0] ofs);
        hit = a.wr && (a.addr == ofs);
    endfunction

    // Next state of the whole register file
    always_comb
    begin
        s_d = s_q;
        urow_done_d = 1'b0;
        // A disable write beats link_enable for one cycle only; hold link_enable low to stay off
        s_d.link_on = link_enable;
        if (hit(acc, `DLAC_OFS_LINK_CTRL_B))
        begin
            s_d.negative_ack_suppress = acc.wdata[`DLAC_BIT_NACK_SUPPRESS];
            s_d.collision_detect_off = acc.wdata[`DLAC_BIT_COLL_OFF];
            if (acc.wdata[`DLAC_BIT_LINK_DISABLE])
            begin
                s_d.link_on = 1'b0;
            end
        end
        else if (hit(acc, `DLAC_OFS_RST_REQ))
        begin
            s_d.rst_hold = (acc.wdata == `DLAC_RST_SIGNATURE);
        end
        else if (hit(acc, `DLAC_OFS_ACC_CTRL_A))
        begin
            s_d.link_clock_select = dlac_clk_sel_t'(acc.wdata[1:0]);
        end
        else if (hit(acc, `DLAC_OFS_SYS_CTRL_A))
        begin
            s_d.system_clock_request = acc.wdata[`DLAC_BIT_CLK_REQ];
            if (s_q.key_urow && acc.wdata[`DLAC_BIT_USER_ROW_DONE])
            begin
                s_d.user_row_done = 1'b1;
                urow_done_d = 1'b1;
            end
        end
        // Key flags: decode sets, completion clears, set wins
        if (keys.prog_done)
        begin
            s_d.key_prog = 1'b0;
        end
        if (keys.erase_done)
        begin
            s_d.key_erase = 1'b0;
        end
        if (keys.urow_key_ok)
        begin
            s_d.key_urow = 1'b1;
        end
        if (keys.prog_key_ok)
        begin
            s_d.key_prog = 1'b1;
        end
        if (keys.erase_key_ok)
        begin
            s_d.key_erase = 1'b1;
        end
        // Reset active flag: clear on read, but a live reset wins
        if (acc.rd && acc.addr == `DLAC_OFS_SYS_STATE)
        begin
            s_d.rst_seen = 1'b0;
        end
        if (sys.in_reset || s_q.rst_hold)
        begin
            s_d.rst_seen = 1'b1;
        end
        // Enabling raises the clock request once
        if (s_d.link_on && !link_on_prev_q)
        begin
            s_d.system_clock_request = 1'b1;
            s_d.link_clock_select = DLAC_CLK_4M;
        end
        // Disabled link loses configuration, keys and clock request
        if (!s_d.link_on)
        begin
            s_d.negative_ack_suppress = 1'b0;
            s_d.collision_detect_off = 1'b0;
            s_d.key_urow = 1'b0;
            s_d.key_prog = 1'b0;
            s_d.key_erase = 1'b0;
            s_d.rst_hold = `DLAC_RST_RST_REQ;
            s_d.link_clock_select = dlac_clk_sel_t'(`DLAC_RST_CLK_SEL);
            s_d.system_clock_request = 1'b0;
            s_d.user_row_done = 1'b0;
            urow_done_d = 1'b0;
        end
        // Read data, registered; unmapped offsets read zero
        // System levels are sampled here, so a read shows them as they stood one cycle earlier
        s_d.rdata = 8'h00;
        if (acc.addr == `DLAC_OFS_LINK_CTRL_B)
        begin
            s_d.rdata[`DLAC_BIT_NACK_SUPPRESS] = s_q.negative_ack_suppress;
            s_d.rdata[`DLAC_BIT_COLL_OFF] = s_q.collision_detect_off;
            s_d.rdata[`DLAC_BIT_LINK_DISABLE] = !s_q.link_on;
        end
        else if (acc.addr == `DLAC_OFS_KEY_STATUS)
        begin
            s_d.rdata[`DLAC_BIT_KEY_UROW] = s_q.key_urow;
            s_d.rdata[`DLAC_BIT_KEY_PROG] = s_q.key_prog;
            s_d.rdata[`DLAC_BIT_KEY_ERASE] = s_q.key_erase;
        end
        else if (acc.addr == `DLAC_OFS_RST_REQ)
        begin
            s_d.rdata[0] = s_q.rst_hold;
        end
        else if (acc.addr == `DLAC_OFS_ACC_CTRL_A)
        begin
            s_d.rdata[1:0] = s_q.link_clock_select;
        end
        else if (acc.addr == `DLAC_OFS_SYS_CTRL_A)
        begin
            s_d.rdata[`DLAC_BIT_USER_ROW_DONE] = s_q.user_row_done;
            s_d.rdata[`DLAC_BIT_CLK_REQ] = s_q.system_clock_request;
        end
        else if (acc.addr == `DLAC_OFS_SYS_STATE)
        begin
            s_d.rdata[`DLAC_BIT_RST_ACTIVE] = s_q.rst_seen;
            s_d.rdata[`DLAC_BIT_ASLEEP] = sys.asleep;
            s_d.rdata[`DLAC_BIT_PROG_READY] = sys.prog_ready;
            s_d.rdata[`DLAC_BIT_UROW_READY] = sys.urow_ready;
            s_d.rdata[`DLAC_BIT_LOCK] = sys.locked;
        end
        else if (acc.addr == `DLAC_OFS_CRC_STATE)
        begin
            s_d.rdata[2:0] = sys.crc_state;
        end
    end

    // Only rst_n resets this state; the requested system reset is an output only
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_q <= '{negative_ack_suppress: 1'b0, collision_detect_off: 1'b0, link_on: 1'b0,
                     key_urow: 1'b0, key_prog: 1'b0, key_erase: 1'b0, rst_hold: `DLAC_RST_RST_REQ,
                     link_clock_select: DLAC_CLK_4M, system_clock_request: 1'b0,
                     user_row_done: 1'b0, rst_seen: 1'b0, rdata: 8'h00};
            urow_done_q <= 1'b0;
            link_on_prev_q <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
            urow_done_q <= urow_done_d;
            link_on_prev_q <= s_d.link_on;
        end
    end

    // Outputs
    assign rdata = s_q.rdata;
    assign link_active = s_q.link_on;
    assign link_clock_select = s_q.link_clock_select;
    assign system_reset_hold = s_q.rst_hold;
    assign system_clock_request = s_q.system_clock_request;
    assign user_row_done_pulse = urow_done_q;
    // Negative acknowledge signature sent when a load or store meets the reset active flag and suppression is off
    assign nack_send = load_store_busy && s_q.rst_seen && !s_q.negative_ack_suppress;
    // Collision is only reported while detection is on
    assign collision_flag = line_collision && !s_q.collision_detect_off && s_q.link_on;

    a_reset_sig: assert property (@(posedge clk) disable iff (!rst_n)
        acc.wr && acc.addr == `DLAC_OFS_RST_REQ && acc.wdata == `DLAC_RST_SIGNATURE && link_enable
        |=> system_reset_hold)
        else $error("reset signature did not hold reset");
    a_reset_rel: assert property (@(posedge clk) disable iff (!rst_n)
        acc.wr && acc.addr == `DLAC_OFS_RST_REQ && acc.wdata != `DLAC_RST_SIGNATURE |=> !system_reset_hold)
        else $error("other value did not release reset");
    a_rst_read: assert property (@(posedge clk) disable iff (!rst_n)
        !acc.wr && acc.addr == `DLAC_OFS_RST_REQ |=> rdata == {7'h00, $past(system_reset_hold)})
        else $error("reset request read wrong");
    a_disable_all: assert property (@(posedge clk) disable iff (!rst_n)
        acc.wr && acc.addr == `DLAC_OFS_LINK_CTRL_B && acc.wdata[`DLAC_BIT_LINK_DISABLE]
        |=> !link_active && !system_clock_request && !system_reset_hold)
        else $error("link disable left state behind");
    a_urow_key: assert property (@(posedge clk) disable iff (!rst_n)
        user_row_done_pulse |-> $past(s_q.key_urow))
        else $error("user row done without key");
    a_clk_enable: assert property (@(posedge clk) disable iff (!rst_n)
        link_enable && !link_on_prev_q && !acc.wr ##1 link_active |-> system_clock_request)
        else $error("clock request not set on enable");
    a_prog_clear: assert property (@(posedge clk) disable iff (!rst_n)
        keys.prog_done && !keys.prog_key_ok |=> !s_q.key_prog)
        else $error("programming key flag stuck");
    a_erase_clear: assert property (@(posedge clk) disable iff (!rst_n)
        keys.erase_done && !keys.erase_key_ok |=> !s_q.key_erase)
        else $error("erase key flag stuck");
    a_nack_hide: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.negative_ack_suppress |-> !nack_send)
        else $error("negative acknowledge not suppressed");
    a_rstflag_set: assert property (@(posedge clk) disable iff (!rst_n)
        sys.in_reset |=> s_q.rst_seen)
        else $error("reset active flag missed");

    // Read paths: rdata shows the state of the cycle in which the address stood
    a_key_read: assert property (@(posedge clk) disable iff (!rst_n)
        acc.addr == `DLAC_OFS_KEY_STATUS
        |=> rdata == {2'h0, $past(s_q.key_urow), $past(s_q.key_prog), $past(s_q.key_erase), 3'h0})
        else $error("key status read wrong");
    a_asleep_read: assert property (@(posedge clk) disable iff (!rst_n)
        acc.addr == `DLAC_OFS_SYS_STATE
        |=> rdata[`DLAC_BIT_ASLEEP] == $past(sys.asleep))
        else $error("asleep flag read wrong");
    a_prog_ready: assert property (@(posedge clk) disable iff (!rst_n)
        acc.addr == `DLAC_OFS_SYS_STATE
        |=> rdata[`DLAC_BIT_PROG_READY] == $past(sys.prog_ready))
        else $error("programming ready flag read wrong");
    a_urow_ready: assert property (@(posedge clk) disable iff (!rst_n)
        acc.addr == `DLAC_OFS_SYS_STATE
        |=> rdata[`DLAC_BIT_UROW_READY] == $past(sys.urow_ready))
        else $error("user row ready flag read wrong");
    a_lock_read: assert property (@(posedge clk) disable iff (!rst_n)
        acc.addr == `DLAC_OFS_SYS_STATE
        |=> rdata[`DLAC_BIT_LOCK] == $past(sys.locked))
        else $error("lock flag read wrong");
    a_crc_read: assert property (@(posedge clk) disable iff (!rst_n)
        acc.addr == `DLAC_OFS_CRC_STATE
        |=> rdata == {5'h00, $past(sys.crc_state)})
        else $error("scan status read wrong");
    a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
        acc.addr inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'hd, 4'he, 4'hf}
        |=> rdata == 8'h00)
        else $error("unmapped offset read nonzero");

    // Enable and disable of the link, and link clock select
    a_off_clears: assert property (@(posedge clk) disable iff (!rst_n)
        !link_enable
        |=> !link_active && !system_clock_request && !system_reset_hold && !user_row_done_pulse)
        else $error("disabled link kept state");
    a_enable_4m: assert property (@(posedge clk) disable iff (!rst_n)
        link_enable && !link_on_prev_q
        |=> link_clock_select == DLAC_CLK_4M)
        else $error("enable did not select 4 MHz");
    a_clksel_16m: assert property (@(posedge clk) disable iff (!rst_n)
        acc.wr && acc.addr == `DLAC_OFS_ACC_CTRL_A && acc.wdata[1:0] == 2'h1 && link_enable && link_on_prev_q
        |=> link_clock_select == DLAC_CLK_16M)
        else $error("16 MHz select not taken");
    a_clksel_8m: assert property (@(posedge clk) disable iff (!rst_n)
        acc.wr && acc.addr == `DLAC_OFS_ACC_CTRL_A && acc.wdata[1:0] == 2'h2 && link_enable && link_on_prev_q
        |=> link_clock_select == DLAC_CLK_8M)
        else $error("8 MHz select not taken");

    // Keys and user row completion
    a_urow_set: assert property (@(posedge clk) disable iff (!rst_n)
        keys.urow_key_ok && link_enable && !acc.wr
        |=> s_q.key_urow)
        else $error("user row key flag not set");
    a_prog_set: assert property (@(posedge clk) disable iff (!rst_n)
        keys.prog_key_ok && link_enable && !acc.wr
        |=> s_q.key_prog)
        else $error("programming key flag not set");
    a_urow_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        acc.wr && acc.addr == `DLAC_OFS_SYS_CTRL_A && acc.wdata[`DLAC_BIT_USER_ROW_DONE] && s_q.key_urow && link_enable
        |=> user_row_done_pulse)
        else $error("user row done did not start programming");
    a_urow_refused: assert property (@(posedge clk) disable iff (!rst_n)
        acc.wr && acc.addr == `DLAC_OFS_SYS_CTRL_A && !s_q.key_urow
        |=> !user_row_done_pulse)
        else $error("user row done taken without key");

    // Clock request, line status and reset flag
    a_system_clock_request_keep: assert property (@(posedge clk) disable iff (!rst_n)
        acc.wr && acc.addr == `DLAC_OFS_SYS_CTRL_A && acc.wdata[`DLAC_BIT_CLK_REQ] && link_enable
        |=> system_clock_request)
        else $error("clock request not raised");
    a_system_clock_request_drop: assert property (@(posedge clk) disable iff (!rst_n)
        acc.wr && acc.addr == `DLAC_OFS_SYS_CTRL_A && !acc.wdata[`DLAC_BIT_CLK_REQ] && link_enable && link_on_prev_q
        |=> !system_clock_request)
        else $error("clock request not withdrawn");
    a_collision_on: assert property (@(posedge clk) disable iff (!rst_n)
        line_collision && link_active && !s_q.collision_detect_off
        |-> collision_flag)
        else $error("collision not reported");
    a_nack_send: assert property (@(posedge clk) disable iff (!rst_n)
        load_store_busy && s_q.rst_seen && !s_q.negative_ack_suppress
        |-> nack_send)
        else $error("negative acknowledge missing");
    a_rstflag_hold: assert property (@(posedge clk) disable iff (!rst_n)
        system_reset_hold
        |=> s_q.rst_seen)
        else $error("held reset not flagged");
    a_rstflag_clear: assert property (@(posedge clk) disable iff (!rst_n)
        acc.rd && acc.addr == `DLAC_OFS_SYS_STATE && !sys.in_reset && !system_reset_hold
        |=> !s_q.rst_seen)
        else $error("reset active flag not cleared by read");
endmodule

// *** verification/dlac_dbg_model.sv ***
// Debugger model that issues register accesses on the link access port
`timescale 1ns/1ps
`include "dlac_cfg.svh"

module dlac_dbg_model
    import dlac_pkg::*;
#(
    parameter logic brownout_at_top = 1'b1
)
(
    // Clock
    input wire logic clk,
    // Access port
    output dlac_acc_t acc,
    input wire logic [7:0] rdata
);
    initial acc = '0;

    // One write; fast link clocks only when the brownout level is at its top
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        begin
            @(posedge clk);
            #1;
            if (a == `DLAC_OFS_ACC_CTRL_A && d[1:0] != 2'h3 && !brownout_at_top)
                d[1:0] = 2'h3;
            acc.addr = a;
            acc.wdata = d;
            acc.wr = 1'b1;
            @(posedge clk);
            #1;
            acc.wr = 1'b0;
            acc.wdata = ~d; // Released data never repeats the last value
        end
    endtask

    // One read; data lands one edge after the address
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        begin
            @(posedge clk);
            #1;
            acc.addr = a;
            acc.rd = 1'b1;
            @(posedge clk);
            #1;
            acc.rd = 1'b0;
            d = rdata;
        end
    endtask
endmodule

// *** verification/tb_top.sv ***
// Self-checking testbench of the debug link access control block
`timescale 1ns/1ps
`include "dlac_cfg.svh"

module tb_top;
    import dlac_pkg::*;
    logic clk;
    logic rst_n;
    logic link_enable;
    logic load_store_busy;
    logic line_collision;
    dlac_acc_t acc;
    logic [7:0] rdata;
    dlac_key_t keys;
    dlac_sys_t sys;
    logic link_active;
    logic nack_send;
    logic collision_flag;
    dlac_clk_sel_t link_clock_select;
    logic system_reset_hold;
    logic system_clock_request;
    logic user_row_done_pulse;
    int err_total;
    int samples_checked;
    logic [7:0] rv;
    logic [2:0] crc_tab [4] = '{3'h0, 3'h1, 3'h2, 3'h4};

    dlac_ctrl DUT (.clk(clk), .rst_n(rst_n), .link_enable(link_enable), .acc(acc), .rdata(rdata),
        .load_store_busy(load_store_busy), .line_collision(line_collision), .keys(keys), .sys(sys),
        .link_active(link_active), .nack_send(nack_send), .collision_flag(collision_flag),
        .link_clock_select(link_clock_select), .system_reset_hold(system_reset_hold),
        .system_clock_request(system_clock_request), .user_row_done_pulse(user_row_done_pulse));
    dlac_dbg_model DBG (.clk(clk), .acc(acc), .rdata(rdata));

    // Clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        begin
            samples_checked++;
            if (seen !== exp)
            begin
                err_total++;
                $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        begin
            DBG.rd(a, rv);
            chk(rv, exp);
        end
    endtask

    // One-cycle event from the key logic
    task automatic kick(input logic [4:0] k);
        begin
            @(posedge clk);
            #1;
            keys = dlac_key_t'(k);
            @(posedge clk);
            #1;
            keys = '0;
        end
    endtask

    task automatic t_clksel();
        for (int i = 0; i < 4; i++)
        begin
            DBG.wr(`DLAC_OFS_ACC_CTRL_A, 8'(i));
            chk({6'h0, link_clock_select}, 8'(i));
        end
    endtask

    task automatic t_reset_request_field();
        begin
            DBG.wr(`DLAC_OFS_RST_REQ, `DLAC_RST_SIGNATURE);
            chk({7'h0, system_reset_hold}, 8'h01);
            rdc(`DLAC_OFS_RST_REQ, 8'h01);
            chk({7'h0, link_active}, 8'h01);
            load_store_busy = 1'b1;
            #1;
            chk({7'h0, nack_send}, 8'h01);
            DBG.wr(`DLAC_OFS_LINK_CTRL_B, 8'h10);
            chk({7'h0, nack_send}, 8'h00);
            DBG.wr(`DLAC_OFS_RST_REQ, 8'h58);
            chk({7'h0, system_reset_hold}, 8'h00);
            rdc(`DLAC_OFS_RST_REQ, 8'h00);
            load_store_busy = 1'b0;
            rdc(`DLAC_OFS_SYS_STATE, 8'h20);
            rdc(`DLAC_OFS_SYS_STATE, 8'h00);
        end
    endtask

    // Every mix of sleep, ready and lock levels, with each scan status code
    task automatic t_status();
        begin
            for (int i = 0; i < 16; i++)
            begin
                sys = dlac_sys_t'({1'b0, i[3:0], crc_tab[i[1:0]]});
                rdc(`DLAC_OFS_SYS_STATE, {3'h0, i[3:1], 1'b0, i[0]});
                rdc(`DLAC_OFS_CRC_STATE, {5'h0, crc_tab[i[1:0]]});
            end
            // A live system reset survives a read; the first read after it ends clears the flag
            sys = dlac_sys_t'(8'h80);
            rdc(`DLAC_OFS_SYS_STATE, 8'h20);
            sys.in_reset = 1'b0;
            rdc(`DLAC_OFS_SYS_STATE, 8'h20);
            rdc(`DLAC_OFS_SYS_STATE, 8'h00);
        end
    endtask

    task automatic t_keys();
        begin
            DBG.wr(`DLAC_OFS_SYS_CTRL_A, 8'h03);
            chk({6'h0, user_row_done_pulse, system_clock_request}, 8'h01);
            kick(5'h10);
            rdc(`DLAC_OFS_KEY_STATUS, 8'h20);
            kick(5'h08);
            rdc(`DLAC_OFS_KEY_STATUS, 8'h30);
            kick(5'h02);
            rdc(`DLAC_OFS_KEY_STATUS, 8'h20);
            // Decode and completion in one cycle: the decode wins
            kick(5'h0a);
            rdc(`DLAC_OFS_KEY_STATUS, 8'h30);
            kick(5'h02);
            rdc(`DLAC_OFS_KEY_STATUS, 8'h20);
            kick(5'h04);
            rdc(`DLAC_OFS_KEY_STATUS, 8'h28);
            kick(5'h01);
            DBG.wr(`DLAC_OFS_KEY_STATUS, 8'hff);
            rdc(`DLAC_OFS_KEY_STATUS, 8'h20);
            // Row data is taken as already in RAM before done is written
            DBG.wr(`DLAC_OFS_SYS_CTRL_A, 8'h02);
            chk({6'h0, user_row_done_pulse, system_clock_request}, 8'h02);
            @(posedge clk);
            #1;
            chk({7'h0, user_row_done_pulse}, 8'h00);
        end
    endtask

    task automatic t_link();
        begin
            line_collision = 1'b1;
            #1;
            chk({7'h0, collision_flag}, 8'h01);
            DBG.wr(`DLAC_OFS_LINK_CTRL_B, 8'h08);
            chk({7'h0, collision_flag}, 8'h00);
            DBG.wr(`DLAC_OFS_LINK_CTRL_B, 8'h04);
            link_enable = 1'b0;
            chk({6'h0, link_active, system_clock_request}, 8'h00);
            rdc(`DLAC_OFS_KEY_STATUS, 8'h00);
            rdc(`DLAC_OFS_LINK_CTRL_B, 8'h04);
            link_enable = 1'b1;
            repeat (3) @(posedge clk);
            #1;
            chk({6'h0, link_active, system_clock_request}, 8'h03);
            chk({6'h0, link_clock_select}, 8'h03);
        end
    endtask

    task automatic conclude();
        begin
            $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
            if (err_total == 0 && samples_checked > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask

    // Watchdog far beyond the under two hundred cycles the tests need
    initial
    begin
        repeat (5000) @(posedge clk);
        err_total++;
        conclude();
    end

    // Main sequence
    initial
    begin
        err_total = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        link_enable = 1'b0;
        load_store_busy = 1'b0;
        line_collision = 1'b0;
        keys = '0;
        sys = '0;
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        link_enable = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk({6'h0, link_clock_select}, 8'h03);
        chk({7'h0, system_clock_request}, 8'h01);
        rdc(4'h5, 8'h00);
        t_clksel();
        t_reset_request_field();
        t_status();
        t_keys();
        t_link();
        conclude();
    end
endmodule
